//--- hdl/ics_pkg.sv
// Package of constants and types for the instruction cycle sequencer.
// How it works
// RQ1 - Every machine cycle lasts exactly four system clocks; all sequencing follows it.
// RQ2 - Instructions that leave program flow alone complete in one machine cycle, except table read.
// RQ3 - Jump, call, subroutine exit, interrupt exit and table read take two cycles.
// RQ4 - Writing the low program counter byte jumps there and adds one cycle.
// RQ5 - A skip test takes one cycle, plus one more when it skips.
// RQ6 - A data test either continues with the next instruction or bypasses it.
// RQ7 - Addition carries above 255; subtraction borrows through carry below 0.
// RQ8 - Add-one and subtract-one change by one, to memory or accumulator.
// RQ9 - AND, OR, XOR, complement use the accumulator and set zero on zero.
// RQ10 - Rotates move one bit; carry variants swap the out bit with carry.
// RQ11 - Bit force high or low rewrites only the addressed bit.
// RQ12 - Call saves the following address; exit resumes there; jump saves nothing.
// RQ13 - Table reads fetch fixed data from program memory.
// RQ14 - The second cycle of a two-cycle op drops the prefetch and refetches.
package ics_pkg;

    // ****************************************
    // Timing and widths
    // ****************************************
    localparam int ICS_PHASES = 4;
    localparam int ICS_PC_W = 11;
    localparam int ICS_STACK_DEPTH = 4;
    localparam logic [10:0] ICS_PC_RESET = 11'h000;
    localparam logic [7:0] ICS_ACC_RESET = 8'h00;

    // ****************************************
    // Operations presented by the decoder
    // ****************************************
    typedef enum logic [4:0] {
        ICS_OP_NOP,
        ICS_OP_MOV_ACC,
        ICS_OP_ADD,
        ICS_OP_ADC,
        ICS_OP_SUB,
        ICS_OP_SBC,
        ICS_OP_AND,
        ICS_OP_OR,
        ICS_OP_XOR,
        ICS_OP_BIT_INVERT,
        ICS_OP_ADD_ONE,
        ICS_OP_SUBTRACT_ONE,
        ICS_OP_ROTATE_LEFT,
        ICS_OP_ROTATE_RIGHT,
        ICS_OP_ROTATE_LEFT_VIA_CARRY,
        ICS_OP_ROTATE_RIGHT_VIA_CARRY,
        ICS_OP_BIT_FORCE_HIGH,
        ICS_OP_BIT_FORCE_LOW,
        ICS_OP_SKIP_ZERO,
        ICS_OP_SKIP_BIT_SET,
        ICS_OP_SKIP_BIT_CLEAR,
        ICS_OP_JUMP,
        ICS_OP_CALL,
        ICS_OP_SUBROUTINE_EXIT,
        ICS_OP_INTERRUPT_EXIT,
        ICS_OP_TABLE_READ,
        ICS_OP_PC_LOW_WRITE
    } ics_op_t;

    // One decoded instruction.
    typedef struct packed {
        ics_op_t op;
        logic to_acc;
        logic [2:0] bit_sel;
        logic [7:0] imm;
        logic [10:0] target;
    } ics_instr_t;

    // Results of the arithmetic and logic unit.
    typedef struct packed {
        logic [7:0] value;
        logic carry;
        logic zero;
        logic write_carry;
        logic write_zero;
    } ics_alu_t;

endpackage

//--- hdl/ics_alu.sv
// Arithmetic and logic unit of the instruction cycle sequencer.
`timescale 1ns/1ps
module ics_alu
    import ics_pkg::*;
(
    input wire ics_op_t op,
    input wire logic [7:0] acc,
    input wire logic [7:0] operand,
    input wire logic carry_in,
    input wire logic [2:0] bit_sel,
    output ics_alu_t result
);

    wire [8:0] sum_add = {1'b0, acc} + {1'b0, operand};
    wire [8:0] sum_adc = sum_add + {8'h00, carry_in};
    wire [8:0] dif_sub = {1'b0, acc} - {1'b0, operand};
    wire [8:0] dif_sbc = dif_sub - {8'h00, ~carry_in};
    wire [7:0] bit_mask = 8'h01 << bit_sel;

    always_comb begin
        result = '0;
        result.value = operand;
        case (op)
            ICS_OP_ADD: begin
                result.value = sum_add[7:0];
                result.carry = sum_add[8]; // RQ7
                result.write_carry = 1'b1;
                result.write_zero = 1'b1;
            end
            ICS_OP_ADC: begin
                result.value = sum_adc[7:0];
                result.carry = sum_adc[8]; // RQ7
                result.write_carry = 1'b1;
                result.write_zero = 1'b1;
            end
            ICS_OP_SUB: begin
                // Carry set means no borrow happened.
                result.value = dif_sub[7:0];
                result.carry = ~dif_sub[8]; // RQ7
                result.write_carry = 1'b1;
                result.write_zero = 1'b1;
            end
            ICS_OP_SBC: begin
                result.value = dif_sbc[7:0];
                result.carry = ~dif_sbc[8]; // RQ7
                result.write_carry = 1'b1;
                result.write_zero = 1'b1;
            end
            ICS_OP_AND: begin
                result.value = acc & operand; // RQ9
                result.write_zero = 1'b1;
            end
            ICS_OP_OR: begin
                result.value = acc | operand; // RQ9
                result.write_zero = 1'b1;
            end
            ICS_OP_XOR: begin
                result.value = acc ^ operand; // RQ9
                result.write_zero = 1'b1;
            end
            ICS_OP_BIT_INVERT: begin
                result.value = ~operand; // RQ9
                result.write_zero = 1'b1;
            end
            ICS_OP_ADD_ONE: begin
                result.value = operand + 8'h01; // RQ8
                result.write_zero = 1'b1;
            end
            ICS_OP_SUBTRACT_ONE: begin
                result.value = operand - 8'h01; // RQ8
                result.write_zero = 1'b1;
            end
            ICS_OP_ROTATE_LEFT: begin
                result.value = {operand[6:0], operand[7]}; // RQ10
            end
            ICS_OP_ROTATE_RIGHT: begin
                result.value = {operand[0], operand[7:1]}; // RQ10
            end
            ICS_OP_ROTATE_LEFT_VIA_CARRY: begin
                result.value = {operand[6:0], carry_in}; // RQ10
                result.carry = operand[7];
                result.write_carry = 1'b1;
            end
            ICS_OP_ROTATE_RIGHT_VIA_CARRY: begin
                result.value = {carry_in, operand[7:1]}; // RQ10
                result.carry = operand[0];
                result.write_carry = 1'b1;
            end
            ICS_OP_BIT_FORCE_HIGH: begin
                result.value = operand | bit_mask; // RQ11
            end
            ICS_OP_BIT_FORCE_LOW: begin
                result.value = operand & ~bit_mask; // RQ11
            end
            default: begin
                result.value = operand;
            end
        endcase
        result.zero = (result.value == 8'h00);
    end

endmodule

//--- hdl/ics_sequencer.sv
// Machine cycle sequencer with program counter, call stack and data path.
`timescale 1ns/1ps
module ics_sequencer
    import ics_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire ics_instr_t fetched,
    input wire logic [7:0] mem_rdata,
    input wire logic [7:0] table_rdata,
    output logic [10:0] fetch_addr,
    output logic [1:0] phase,
    output logic cycle_start,
    output logic [7:0] mem_wdata,
    output logic mem_we,
    output logic [10:0] table_addr,
    output logic [7:0] table_data,
    output logic [7:0] acc,
    output logic carry,
    output logic zero,
    output logic [10:0] pc,
    output logic busy
);

    // ****************************************
    // Cycle states
    // ****************************************
    typedef enum logic [1:0] {
        ICS_ST_EXEC,
        ICS_ST_FLUSH
    } ics_state_t;

    ics_state_t state;
    ics_state_t next_state;
    ics_instr_t instr;
    logic [10:0] stack [ICS_STACK_DEPTH];
    logic [1:0] sp;
    logic [7:0] table_latch;
    ics_alu_t alu_out;

    // Decoding used for the two-cycle and data-write classifications below.
    function automatic logic is_two_cycle(input ics_op_t op);
        case (op)
            ICS_OP_JUMP, ICS_OP_CALL, ICS_OP_SUBROUTINE_EXIT,
            ICS_OP_INTERRUPT_EXIT, ICS_OP_TABLE_READ, ICS_OP_PC_LOW_WRITE: begin
                is_two_cycle = 1'b1;
            end
            default: begin
                is_two_cycle = 1'b0;
            end
        endcase
    endfunction

    function automatic logic writes_data(input ics_op_t op);
        case (op)
            ICS_OP_ADD, ICS_OP_ADC, ICS_OP_SUB, ICS_OP_SBC, ICS_OP_AND, ICS_OP_OR,
            ICS_OP_XOR, ICS_OP_BIT_INVERT, ICS_OP_ADD_ONE, ICS_OP_SUBTRACT_ONE,
            ICS_OP_ROTATE_LEFT, ICS_OP_ROTATE_RIGHT, ICS_OP_ROTATE_LEFT_VIA_CARRY,
            ICS_OP_ROTATE_RIGHT_VIA_CARRY, ICS_OP_MOV_ACC: begin
                writes_data = 1'b1;
            end
            default: begin
                writes_data = 1'b0;
            end
        endcase
    endfunction

    // ****************************************
    // Decode and selection
    // ****************************************
    wire last_phase = (phase == 2'(ICS_PHASES - 1)); // RQ1
    wire exec_end = last_phase && (state == ICS_ST_EXEC);
    // A move towards the accumulator loads the operand; the other way it stores the accumulator.
    wire [7:0] alu_operand = (instr.op == ICS_OP_MOV_ACC && !instr.to_acc) ? acc : mem_rdata;
    wire [7:0] imm_or_mem = instr.to_acc ? mem_rdata : instr.imm;
    wire test_bit = mem_rdata[instr.bit_sel];
    wire skip_zero = (instr.op == ICS_OP_SKIP_ZERO) && (mem_rdata == 8'h00);
    wire skip_set = (instr.op == ICS_OP_SKIP_BIT_SET) && test_bit;
    wire skip_clear = (instr.op == ICS_OP_SKIP_BIT_CLEAR) && !test_bit;
    wire take_skip = skip_zero || skip_set || skip_clear; // RQ6
    wire two_cycle = is_two_cycle(instr.op) || take_skip; // RQ3 RQ4 RQ5
    wire is_binary = (instr.op inside {ICS_OP_ADD, ICS_OP_ADC, ICS_OP_SUB, ICS_OP_SBC,
                                       ICS_OP_AND, ICS_OP_OR, ICS_OP_XOR});
    wire to_memory = writes_data(instr.op) && !instr.to_acc; // RQ8
    wire bit_write = (instr.op inside {ICS_OP_BIT_FORCE_HIGH, ICS_OP_BIT_FORCE_LOW});
    wire [1:0] sp_top = sp - 2'd1;
    wire [10:0] pc_next_seq = pc + 11'd1;
    wire [10:0] pc_low_target = {pc[10:8], alu_out.value};

    ics_alu u_alu (
        .op(instr.op),
        .acc(acc),
        .operand(is_binary ? imm_or_mem : alu_operand),
        .carry_in(carry),
        .bit_sel(instr.bit_sel),
        .result(alu_out)
    );

    // Flow target chosen at the end of the executing cycle.
    logic [10:0] next_pc;
    always_comb begin
        next_pc = pc_next_seq; // RQ2
        case (instr.op)
            ICS_OP_JUMP, ICS_OP_CALL: begin
                next_pc = instr.target; // RQ12
            end
            ICS_OP_SUBROUTINE_EXIT, ICS_OP_INTERRUPT_EXIT: begin
                next_pc = stack[sp_top]; // RQ12
            end
            ICS_OP_PC_LOW_WRITE: begin
                next_pc = pc_low_target; // RQ4
            end
            ICS_OP_TABLE_READ: begin
                next_pc = pc; // RQ13
            end
            default: begin
                // The skipped word is the prefetch that the flush drops, so the
                // sequential address already lands on the word after it.
                next_pc = pc_next_seq; // RQ6
            end
        endcase
    end

    always_comb begin
        next_state = state;
        case (state)
            ICS_ST_EXEC: begin
                if (exec_end && two_cycle) begin
                    next_state = ICS_ST_FLUSH; // RQ3 RQ5
                end
            end
            ICS_ST_FLUSH: begin
                if (last_phase) begin
                    next_state = ICS_ST_EXEC; // RQ14
                end
            end
            default: begin
                next_state = ICS_ST_EXEC;
            end
        endcase
    end

    assign cycle_start = (phase == 2'd0);
    assign busy = (state == ICS_ST_FLUSH);
    assign fetch_addr = pc;
    assign table_addr = (instr.op == ICS_OP_TABLE_READ) ? instr.target : pc;
    assign table_data = table_latch;

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            phase <= 2'd0;
        end else begin
            phase <= phase + 2'd1; // RQ1
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= ICS_ST_EXEC;
        end else begin
            state <= next_state;
        end
    end

    // The instruction is latched once per cycle; in the flush cycle the stale prefetch
    // is thrown away and the fetch from the new address is taken at its end.
    always_ff @(posedge clk) begin
        if (rst) begin
            instr <= '0;
        end else if (last_phase) begin
            instr <= (exec_end && two_cycle) ? '0 : fetched; // RQ14
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pc <= ICS_PC_RESET;
        end else if (exec_end) begin
            pc <= next_pc;
        end else if (last_phase && state == ICS_ST_FLUSH) begin
            pc <= pc_next_seq; // RQ14
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sp <= 2'd0;
        end else if (exec_end && instr.op == ICS_OP_CALL) begin
            // While the call executes the counter already points past it.
            stack[sp] <= pc; // RQ12
            sp <= sp + 2'd1;
        end else if (exec_end && instr.op inside {ICS_OP_SUBROUTINE_EXIT,
                                                  ICS_OP_INTERRUPT_EXIT}) begin
            sp <= sp_top; // RQ12
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            acc <= ICS_ACC_RESET;
            carry <= 1'b0;
            zero <= 1'b0;
            table_latch <= 8'h00;
        end else if (exec_end) begin
            if (writes_data(instr.op) && instr.to_acc) begin
                acc <= alu_out.value; // RQ9
            end
            if (alu_out.write_carry) begin
                carry <= alu_out.carry; // RQ7 RQ10
            end
            if (alu_out.write_zero) begin
                zero <= alu_out.zero; // RQ9
            end
            if (instr.op == ICS_OP_TABLE_READ) begin
                table_latch <= table_rdata; // RQ13
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mem_we <= 1'b0;
            mem_wdata <= 8'h00;
        end else begin
            mem_we <= exec_end && (to_memory || bit_write); // RQ11
            mem_wdata <= alu_out.value;
        end
    end

endmodule

//--- verif/ics_sequencer_asserts.sv
// Concurrent checks of machine cycle timing on the sequencer ports.
`timescale 1ns/1ps
module ics_sequencer_asserts
    import ics_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire ics_instr_t fetched,
    input wire logic [10:0] fetch_addr,
    input wire logic [1:0] phase,
    input wire logic cycle_start,
    input wire logic mem_we,
    input wire logic [10:0] table_addr,
    input wire logic [7:0] acc,
    input wire logic carry,
    input wire logic zero,
    input wire logic [10:0] pc,
    input wire logic busy
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // ****************************************
    // Cycle timing
    // ****************************************
    a_four_phase: assert property (cycle_start |=> !cycle_start [*3] ##1 cycle_start)
        else $error("machine cycle is not four clocks");
    a_start_decode: assert property (cycle_start == (phase == 2'h0))
        else $error("cycle start does not match phase zero");
    // State may only move on an execution edge, so a stray update shows up here.
    a_exec_edge_only: assert property (phase != 2'h3 |=> $stable(pc) && $stable(acc) &&
        $stable(carry) && $stable(zero))
        else $error("state changed outside the execution edge");
    a_busy_span: assert property ($rose(busy) |-> phase == 2'h0 ##0 busy [*4] ##1 !busy)
        else $error("flush cycle is not one machine cycle");
    // The flush only moves the counter past the refetched word at its end.
    a_flush_frozen: assert property (busy |=> $stable(acc) && $stable(carry) &&
        (cycle_start ? pc == $past(pc) + 11'h001 : $stable(pc)))
        else $error("instruction executed during flush");
    a_fetch_at_pc: assert property (fetch_addr == pc)
        else $error("fetch address differs from program counter");
    a_write_pulse: assert property (mem_we |=> !mem_we)
        else $error("memory write longer than one clock");
    a_write_timing: assert property (mem_we |-> (phase == 2'h0 || phase == 2'h1) && !busy)
        else $error("memory write away from execution edge");
    a_table_idle: assert property (cycle_start && $past(fetched.op) != ICS_OP_TABLE_READ
        |-> table_addr == pc)
        else $error("table address not at program counter");
    // A fetched table read points the table address at its target for its own cycle.
    a_table_target: assert property (cycle_start && !busy &&
        $past(fetched.op) == ICS_OP_TABLE_READ |-> table_addr == $past(fetched.target))
        else $error("table address not at its target");

    cover property ($rose(busy));
    cover property (mem_we);
    cover property ($rose(carry));
endmodule

bind ics_sequencer ics_sequencer_asserts chk_u (
    .clk, .rst, .fetched, .fetch_addr, .phase, .cycle_start, .mem_we,
    .table_addr, .acc, .carry, .zero, .pc, .busy
);

//--- verif/instruction_cycle_sequencer_tb.sv
// Self-checking testbench for the instruction cycle sequencer.
`timescale 1ns/1ps
module instruction_cycle_sequencer_tb
    import ics_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    ics_instr_t fetched = '0;
    logic [7:0] mem_rdata = 8'h00;
    logic [7:0] table_rdata = 8'h00;
    logic [10:0] fetch_addr, table_addr, pc;
    logic [1:0] phase;
    logic cycle_start, mem_we, carry, zero, busy;
    logic [7:0] mem_wdata, table_data, acc;
    logic [7:0] wr_d = 8'h00;
    logic [10:0] epc = 11'h000;
    int bad_count = 0;
    int n_compared = 0;
    int wr_n = 0;

    always #10 clk = ~clk;

    ics_sequencer dut_u (
        .clk, .rst, .fetched, .mem_rdata, .table_rdata, .fetch_addr, .phase,
        .cycle_start, .mem_wdata, .mem_we, .table_addr, .table_data, .acc,
        .carry, .zero, .pc, .busy
    );

    // Writes are caught here because the pulse is still high when the task returns and is sampled after it.
    always @(posedge clk) begin
        if (mem_we === 1'b1) begin
            wr_n <= wr_n + 1;
            wr_d <= mem_wdata;
        end
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input logic ok, input string msg);
        n_compared++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask

    task automatic results();
        $display("Compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // The word is fetched at one cycle end and runs in the next cycle, so its operand
    // must still stand then; a no-op is fetched behind it.
    task automatic run(input ics_op_t op, input logic ta, input logic [2:0] b,
                       input logic [7:0] v, input logic [10:0] tgt, input logic two,
                       input logic [10:0] npc);
        @(posedge clk);
        fetched <= '{op: op, to_acc: ta, bit_sel: b, imm: v, target: tgt};
        mem_rdata <= v;
        @(posedge clk iff phase == 2'd3);
        fetched <= '0;
        @(posedge clk iff phase == 2'd3);
        @(negedge clk);
        chk(busy === two, "busy level");
        chk(pc === npc, "program counter");
        epc = npc;
        if (two) begin
            @(posedge clk iff phase == 2'd3);
            @(negedge clk);
            chk(busy === 1'b0, "flush too long");
            chk(pc === npc + 11'h001, "refetch address");
            epc = npc + 11'h001;
        end
    endtask

    task automatic alu(input ics_op_t op, input logic ta, input logic [2:0] b,
                       input logic [7:0] v);
        run(op, ta, b, v, 11'h000, 1'b0, epc + 11'h002);
    endtask

    task automatic wchk(input logic [7:0] exp);
        int w;
        w = wr_n;
        alu(ICS_OP_NOP, 1'b0, 3'h0, 8'h00);
        chk(wr_d === exp && wr_n == w + 1, "memory write");
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_arith();
        alu(ICS_OP_MOV_ACC, 1'b1, 3'h0, 8'hF0);
        alu(ICS_OP_ADD, 1'b1, 3'h0, 8'h20);
        chk(acc === 8'h10 && carry === 1'b1, "add carry");
        alu(ICS_OP_SUB, 1'b1, 3'h0, 8'h20);
        chk(acc === 8'hF0 && carry === 1'b0, "sub borrow");
        alu(ICS_OP_SUB, 1'b1, 3'h0, 8'h10);
        chk(acc === 8'hE0 && carry === 1'b1, "sub no borrow");
        alu(ICS_OP_ADC, 1'b1, 3'h0, 8'h0F);
        chk(acc === 8'hF0 && carry === 1'b0, "add with carry");
        alu(ICS_OP_SBC, 1'b1, 3'h0, 8'h0F);
        chk(acc === 8'hE0 && carry === 1'b1, "sub with borrow");
        alu(ICS_OP_ADD_ONE, 1'b1, 3'h0, 8'hFF);
        chk(acc === 8'h00 && zero === 1'b1, "add one wrap");
        alu(ICS_OP_SUBTRACT_ONE, 1'b0, 3'h0, 8'h00);
        wchk(8'hFF);
        chk(acc === 8'h00, "memory variant kept acc");
    endtask

    task automatic t_logic();
        alu(ICS_OP_OR, 1'b1, 3'h0, 8'h81);
        chk(acc === 8'h81 && zero === 1'b0, "or");
        alu(ICS_OP_AND, 1'b1, 3'h0, 8'h7E);
        chk(acc === 8'h00 && zero === 1'b1, "and zero");
        alu(ICS_OP_XOR, 1'b1, 3'h0, 8'h3C);
        chk(acc === 8'h3C && zero === 1'b0, "xor");
        alu(ICS_OP_BIT_INVERT, 1'b1, 3'h0, 8'hFF);
        chk(acc === 8'h00 && zero === 1'b1, "invert zero");
        alu(ICS_OP_ADD, 1'b1, 3'h0, 8'h00);
        alu(ICS_OP_ROTATE_LEFT_VIA_CARRY, 1'b1, 3'h0, 8'h81);
        chk(acc === 8'h02 && carry === 1'b1, "rotate left carry");
        alu(ICS_OP_ROTATE_RIGHT_VIA_CARRY, 1'b1, 3'h0, 8'h80);
        chk(acc === 8'hC0 && carry === 1'b0, "rotate right carry");
        alu(ICS_OP_ROTATE_LEFT, 1'b1, 3'h0, 8'h81);
        chk(acc === 8'h03, "rotate left");
        alu(ICS_OP_ROTATE_RIGHT, 1'b1, 3'h0, 8'h81);
        chk(acc === 8'hC0, "rotate right");
    endtask

    task automatic t_bits();
        alu(ICS_OP_BIT_FORCE_HIGH, 1'b0, 3'h3, 8'hA0);
        wchk(8'hA8);
        alu(ICS_OP_BIT_FORCE_LOW, 1'b0, 3'h7, 8'hA0);
        wchk(8'h20);
    endtask

    task automatic t_skips();
        run(ICS_OP_SKIP_ZERO, 1'b0, 3'h0, 8'h00, 11'h000, 1'b1, epc + 11'h002);
        run(ICS_OP_SKIP_ZERO, 1'b0, 3'h0, 8'h01, 11'h000, 1'b0, epc + 11'h002);
        run(ICS_OP_SKIP_BIT_SET, 1'b0, 3'h2, 8'h04, 11'h000, 1'b1, epc + 11'h002);
        run(ICS_OP_SKIP_BIT_SET, 1'b0, 3'h2, 8'hFB, 11'h000, 1'b0, epc + 11'h002);
        run(ICS_OP_SKIP_BIT_CLEAR, 1'b0, 3'h5, 8'hDF, 11'h000, 1'b1, epc + 11'h002);
        run(ICS_OP_SKIP_BIT_CLEAR, 1'b0, 3'h5, 8'h20, 11'h000, 1'b0, epc + 11'h002);
    endtask

    task automatic t_branch();
        run(ICS_OP_JUMP, 1'b0, 3'h0, 8'h00, 11'h155, 1'b1, 11'h155);
        run(ICS_OP_CALL, 1'b0, 3'h0, 8'h00, 11'h2A0, 1'b1, 11'h2A0);
        alu(ICS_OP_NOP, 1'b0, 3'h0, 8'h00);
        run(ICS_OP_SUBROUTINE_EXIT, 1'b0, 3'h0, 8'h00, 11'h000, 1'b1, 11'h157);
        run(ICS_OP_CALL, 1'b0, 3'h0, 8'h00, 11'h300, 1'b1, 11'h300);
        run(ICS_OP_INTERRUPT_EXIT, 1'b0, 3'h0, 8'h00, 11'h000, 1'b1, 11'h159);
        alu(ICS_OP_MOV_ACC, 1'b1, 3'h0, 8'h40);
        run(ICS_OP_PC_LOW_WRITE, 1'b1, 3'h0, 8'h40, 11'h000, 1'b1, 11'h140);
    endtask

    task automatic t_table();
        @(posedge clk);
        table_rdata <= 8'h5B;
        fork
            run(ICS_OP_TABLE_READ, 1'b0, 3'h0, 8'h00, 11'h3C7, 1'b1, epc + 11'h001);
            begin
                @(posedge clk iff phase == 2'd3);
                @(negedge clk);
                chk(table_addr === 11'h3C7, "table address");
            end
        join
        chk(table_data === 8'h5B, "table data");
    endtask

    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk(pc === 11'h000 && acc === 8'h00 && phase === 2'h0, "reset state");
        t_arith();
        t_logic();
        t_bits();
        t_skips();
        t_branch();
        t_table();
        results();
    end

    // The full run needs well under a thousand clocks; ten thousand is ample.
    initial begin
        #200000;
        bad_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        results();
    end
endmodule
